// ==== hw/vrp_voltage_path.sv ====
// voltage channel: phase delay, smoothing filter, waveform, rms, irq
// assumes adc samples arrive on the master clock with a valid strobe
// and that the host read of the status register is a one-cycle strobe

////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1 - waveform only when mode 11 and enabled
// RULE2 - 16-bit sample sign-extended to 24 bits
// RULE3 - converter span 0x2852 down to 0xD7AE
// RULE4 - single-pole 140 Hz filter before waveform
// RULE5 - multiplier gets unfiltered samples
// RULE6 - amplifier gains 1, 2, 4, 8, 16
// RULE7 - mode bits 12:11 pick four sample rates
// RULE8 - new sample drives irq low
// RULE9 - rms is mean absolute value, 24-bit
// RULE10 - rms updated at clock over four
// RULE11 - full-scale 60 Hz reads about 0x17D338
// RULE12 - rms settles 220 ms / 670 ms
// RULE13 - signed 12-bit offset added to rms
// RULE14 - host derives offset from two levels
// RULE15 - host reads rms near zero crossings
// RULE16 - trim is six-bit, 0x21 to 0x1F
// RULE17 - trim 0x0D means zero added delay
// RULE18 - one trim step is clock over eight
// RULE19 - lower trim advances voltage channel
// RULE20 - host sets sample-ready enable bit 3
// RULE21 - irq low until status read-and-clear
// RULE22 - rate codes 0..3 divide by 1,2,4,8
// RULE23 - delay line at clock/8, tap from trim
module vrp_voltage_path (
  // clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // converter side
  input  wire logic [vrp_pkg::ADC_W-1:0]    adc_sample_i,
  input  wire logic                         adc_valid_i,
  input  wire logic [2:0]                   gain_sel_i,
  output logic      [2:0]                   pga_gain_o,
  // control fields
  input  wire logic [1:0]                   mode_wave_sel_i,
  input  wire logic [1:0]                   mode_rate_sel_i,
  input  wire logic                         sample_ready_enable_i,
  input  wire logic [vrp_pkg::OFS_W-1:0]    voltage_rms_offset_i,
  input  wire logic [vrp_pkg::TRIM_W-1:0]   phase_delay_trim_i,
  input  wire logic                         status_read_i,
  // results
  output logic      [vrp_pkg::WAVE_W-1:0]   waveform_o,
  output logic      [vrp_pkg::RMS_W-1:0]    voltage_rms_value_o,
  output logic      [vrp_pkg::WAVE_W-1:0]   power_sample_o,
  output logic                              irq_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic rate_hit(input logic [vrp_pkg::RATE_CNT_W-1:0] c,
                                    input logic [1:0] sel);
    logic [vrp_pkg::RATE_CNT_W-1:0] mask;
    mask = {vrp_pkg::RATE_CNT_W{1'b1}} >> (2'h3 - sel);
    return (c & mask) == '0;
  endfunction

  function automatic logic [vrp_pkg::WAVE_W-1:0] sext24(
    input logic [vrp_pkg::ADC_W-1:0] v);
    return {{(vrp_pkg::WAVE_W - vrp_pkg::ADC_W){v[vrp_pkg::ADC_W-1]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // rate dividers
  logic [vrp_pkg::RATE_CNT_W-1:0] rate_cnt;
  logic                           rms_tick;
  logic                           ph_tick;
  logic                           rate_tick;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rate_cnt <= '0;
    end else begin
      rate_cnt <= rate_cnt + 10'h001;
    end
  end

  assign rms_tick  = rate_cnt[1:0] == 2'h0;                     // [RULE10]
  assign ph_tick   = rate_cnt[2:0] == 3'h0;                     // [RULE18]
  assign rate_tick = rate_hit(rate_cnt, mode_rate_sel_i);  // [RULE7] [RULE22]

  ////////////////////////////////////////////////////////////////////////////
  // amplifier gain code, out-of-range codes saturate at x16
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pga_gain_o <= 3'h0;
    end else begin
      pga_gain_o <= (gain_sel_i > vrp_pkg::GAIN_CODE_MAX) ?
                    vrp_pkg::GAIN_CODE_MAX : gain_sel_i;        // [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter capture, held between strobes, clipped to the span
  logic signed [vrp_pkg::ADC_W-1:0] adc_in;
  logic signed [vrp_pkg::ADC_W-1:0] adc_clip;
  logic signed [vrp_pkg::ADC_W-1:0] adc_hold;

  assign adc_in   = adc_sample_i;
  assign adc_clip = (adc_in > vrp_pkg::ADC_POS_MAX) ? vrp_pkg::ADC_POS_MAX :
                    (adc_in < vrp_pkg::ADC_NEG_MAX) ? vrp_pkg::ADC_NEG_MAX :
                    adc_in;                                     // [RULE3]

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      adc_hold <= '0;
    end else if (adc_valid_i) begin
      adc_hold <= adc_clip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase delay line
  vrp_dly_if dly ();

  vrp_dly_mem u_mem (
    .core_clk_i (core_clk_i),
    .dly        (dly.mem)
  );

  logic [vrp_pkg::TRIM_W-1:0] trim_eff;
  logic [vrp_pkg::TRIM_W-1:0] tap;
  logic [vrp_pkg::DLY_AW-1:0] wr_ptr;
  logic                       ph_rd_valid;
  logic [vrp_pkg::DLY_AW:0]   fill_cnt;
  logic                       rd_ok;
  logic [vrp_pkg::ADC_W-1:0]  dly_q;

  // 0x20 lies outside the legal range and is pulled to the most negative
  assign trim_eff = (phase_delay_trim_i == vrp_pkg::TRIM_ILLEGAL) ?
                    vrp_pkg::TRIM_MIN : phase_delay_trim_i;     // [RULE16]
  // centre 0x0D lands on the nominal tap; lower codes read newer samples
  assign tap = trim_eff + vrp_pkg::TAP_BIAS;     // [RULE17] [RULE19] [RULE23]

  assign dly.wr_en   = ph_tick;
  assign dly.wr_addr = wr_ptr;
  assign dly.wr_data = adc_hold;
  assign dly.rd_en   = ph_tick;
  // tap 0 reads the slot written one step earlier, never the one being
  // overwritten, so the most negative trim gives the shortest delay
  assign dly.rd_addr = wr_ptr - tap - 6'h01;
  // slots not yet written since reset read as zero: an unknown would
  // stay in the filter and rms accumulators for good
  assign dly_q       = rd_ok ? dly.rd_data : '0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr      <= '0;
      ph_rd_valid <= 1'b0;
      fill_cnt    <= '0;
      rd_ok       <= 1'b0;
    end else begin
      wr_ptr      <= ph_tick ? wr_ptr + 6'h01 : wr_ptr;         // [RULE23]
      ph_rd_valid <= ph_tick;
      if (ph_tick && !fill_cnt[vrp_pkg::DLY_AW]) begin
        fill_cnt <= fill_cnt + 7'h01;
      end
      if (ph_tick) begin
        rd_ok <= fill_cnt > {1'b0, tap};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier feed: delayed but unfiltered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      power_sample_o <= '0;
    end else if (ph_rd_valid) begin
      power_sample_o <= sext24(dly_q);                          // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-pole smoothing filter, runs at clk/8
  logic signed [vrp_pkg::LPF_ACC_W-1:0] lpf_acc;
  logic signed [vrp_pkg::LPF_ACC_W-1:0] lpf_in;
  logic signed [vrp_pkg::LPF_ACC_W-1:0] lpf_out_w;
  logic signed [vrp_pkg::ADC_W-1:0]     lpf_y;
  logic signed [vrp_pkg::ADC_W-1:0]     lpf_rd;

  assign lpf_rd    = dly_q;
  assign lpf_in    = vrp_pkg::LPF_ACC_W'(lpf_rd);
  assign lpf_out_w = lpf_acc >>> vrp_pkg::LPF_SHIFT;
  assign lpf_y     = lpf_out_w[vrp_pkg::ADC_W-1:0];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lpf_acc <= '0;
    end else if (ph_rd_valid) begin
      lpf_acc <= lpf_acc + lpf_in - lpf_out_w;                  // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform register and sample-ready request
  logic wave_mode;
  logic wave_load;
  logic irq_pend;

  assign wave_mode = (mode_wave_sel_i == vrp_pkg::MODE_VOLT_WAVE) &&
                     sample_ready_enable_i;            // [RULE1] [RULE20]
  assign wave_load = wave_mode && rate_tick;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      waveform_o <= '0;
    end else if (wave_load) begin
      waveform_o <= sext24(lpf_y);                    // [RULE2] [RULE4]
    end
  end

  // a new sample in the clearing cycle keeps the request set
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_pend <= 1'b0;
      irq_n_o  <= 1'b1;
    end else begin
      irq_pend <= wave_load | (irq_pend & ~status_read_i);      // [RULE21]
      irq_n_o  <= ~(wave_load | (irq_pend & ~status_read_i));   // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rms: mean absolute value of the filtered signal at clk/4
  logic [vrp_pkg::ADC_W-1:0]     lpf_abs;
  logic [vrp_pkg::MAV_ACC_W-1:0] mav_acc;
  logic [vrp_pkg::MAV_ACC_W-1:0] mav_w;
  logic [vrp_pkg::ADC_W-1:0]     mav;
  logic [24:0]                   rms_raw;
  logic signed [26:0]            rms_sum;
  logic [vrp_pkg::RMS_W-1:0]     next_rms;

  assign lpf_abs = lpf_y[vrp_pkg::ADC_W-1] ? 16'(-lpf_y) : 16'(lpf_y);
  assign mav_w   = mav_acc >> vrp_pkg::RMS_SHIFT;
  assign mav     = mav_w[vrp_pkg::ADC_W-1:0];
  // mean-abs to rms form factor folded into one gain
  assign rms_raw = 25'(mav) * 25'(vrp_pkg::RMS_GAIN);           // [RULE11]
  assign rms_sum = $signed({2'b00, rms_raw}) +
                   27'(signed'(voltage_rms_offset_i));          // [RULE13]
  // negative results read zero rather than wrapping high
  assign next_rms = rms_sum[26] ? '0 :
                    (rms_sum[25:24] != 2'b00) ? vrp_pkg::RMS_SAT :
                    rms_sum[23:0];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mav_acc <= '0;
    end else if (rms_tick) begin
      // time constant sets the 220 ms / 670 ms settling
      mav_acc <= mav_acc + vrp_pkg::MAV_ACC_W'(lpf_abs) - mav_w; // [RULE12]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      voltage_rms_value_o <= '0;
    end else if (rms_tick) begin
      voltage_rms_value_o <= next_rms;                 // [RULE9] [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_WAVE_GATED: assert property ( // [RULE1]
    $changed(waveform_o) |-> $past(wave_mode))
    else $error("waveform changed outside voltage waveform mode");

  AST_WAVE_SEXT: assert property ( // [RULE2]
    waveform_o[23:16] == {8{waveform_o[15]}})
    else $error("waveform upper byte is not a sign extension");

  AST_ADC_SPAN: assert property ( // [RULE3]
    adc_hold <= vrp_pkg::ADC_POS_MAX && adc_hold >= vrp_pkg::ADC_NEG_MAX)
    else $error("held converter sample outside span");

  AST_POWER_UNFILT: assert property ( // [RULE5]
    ph_rd_valid |=> power_sample_o == sext24($past(dly_q)))
    else $error("multiplier feed is not the raw delayed sample");

  AST_PGA_RANGE: assert property ( // [RULE6]
    pga_gain_o <= vrp_pkg::GAIN_CODE_MAX)
    else $error("amplifier gain code out of range");

  AST_LOAD_ON_RATE: assert property ( // [RULE7]
    wave_load && mode_rate_sel_i == 2'h3 |-> rate_cnt[9:0] == 10'h000)
    else $error("slowest rate loaded off its tick");

  AST_IRQ_SET: assert property ( // [RULE8]
    wave_load |=> !irq_n_o)
    else $error("irq not asserted after new sample");

  AST_IRQ_HOLD: assert property ( // [RULE21]
    !irq_n_o && !status_read_i && !wave_load |=> !irq_n_o)
    else $error("irq released without status read");

  AST_IRQ_CLEAR: assert property ( // [RULE21]
    !irq_n_o && status_read_i && !wave_load |=> irq_n_o)
    else $error("irq not released by status read");

  AST_RMS_RATE: assert property ( // [RULE10]
    rms_tick |=> !rms_tick [*3] ##1 rms_tick)
    else $error("rms update spacing is not four cycles");

  AST_RMS_ONLY_TICK: assert property ( // [RULE9]
    $changed(voltage_rms_value_o) |-> $past(rms_tick))
    else $error("rms changed between updates");

  AST_PH_STEP: assert property ( // [RULE18]
    ph_tick |=> !ph_tick [*7] ##1 ph_tick)
    else $error("delay line step is not eight cycles");

  AST_TRIM_LEGAL: assert property ( // [RULE16]
    trim_eff != vrp_pkg::TRIM_ILLEGAL)
    else $error("illegal trim reached the delay line");

  AST_TRIM_CENTRE: assert property ( // [RULE17]
    phase_delay_trim_i == vrp_pkg::TRIM_CENTRE |-> tap == vrp_pkg::TAP_CENTRE)
    else $error("centre trim does not select the nominal tap");

  COV_WAVE_LOAD: cover property (wave_load);
  COV_IRQ_CLEAR: cover property (!irq_n_o ##1 status_read_i ##1 irq_n_o);
  COV_RMS_NONZERO: cover property (voltage_rms_value_o != '0);
  COV_SET_AND_CLEAR: cover property (wave_load && status_read_i);

endmodule

// ==== hw/vrp_pkg.sv ====
// package for the voltage-channel rms and phase path
// assumes one 10 MHz master clock and a synchronous active-high reset
package vrp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking and rates
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned RMS_DIV     = 4;
  localparam int unsigned PH_DIV      = 8;
  localparam int unsigned SRATE_DIV   = 128;
  localparam int unsigned RATE_CNT_W  = 10;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADC_W   = 16;
  localparam int unsigned WAVE_W  = 24;
  localparam int unsigned RMS_W   = 24;
  localparam int unsigned OFS_W   = 12;
  localparam int unsigned TRIM_W  = 6;
  localparam int unsigned DLY_AW  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // mode field and codes
  localparam logic [1:0] MODE_VOLT_WAVE = 2'h3;
  localparam logic [2:0] GAIN_CODE_MAX  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // converter span at unity gain
  localparam logic signed [ADC_W-1:0] ADC_POS_MAX = 16'sh2852;
  localparam logic signed [ADC_W-1:0] ADC_NEG_MAX = 16'shD7AE;

  ////////////////////////////////////////////////////////////////////////////
  // phase trim
  localparam logic [TRIM_W-1:0] TRIM_CENTRE  = 6'h0D;
  localparam logic [TRIM_W-1:0] TRIM_MIN     = 6'h21;
  localparam logic [TRIM_W-1:0] TRIM_MAX     = 6'h1F;
  localparam logic [TRIM_W-1:0] TRIM_ILLEGAL = 6'h20;
  localparam logic [TRIM_W-1:0] TAP_BIAS     = 6'h1F;
  localparam logic [TRIM_W-1:0] TAP_CENTRE   = 6'h2C;

  ////////////////////////////////////////////////////////////////////////////
  // smoothing filter: single pole, shift picked for ~140 Hz at clk/8
  localparam int unsigned LPF_CUT_HZ = 140;
  localparam int unsigned LPF_SHIFT  =
    $clog2(CLK_HZ / PH_DIV / (6 * LPF_CUT_HZ)) - 1;
  localparam int unsigned LPF_ACC_W  = ADC_W + LPF_SHIFT + 2;

  ////////////////////////////////////////////////////////////////////////////
  // rms estimator: mean absolute value, tau ~ one third of 95% settle
  localparam int unsigned RMS_SETTLE95_MS = 220;
  localparam int unsigned RMS_FINAL_MS    = 670;
  localparam int unsigned RMS_SHIFT       =
    $clog2(CLK_HZ / RMS_DIV / 1000 * RMS_SETTLE95_MS / 3) - 1;
  localparam int unsigned MAV_ACC_W       = ADC_W + RMS_SHIFT + 2;
  localparam logic [8:0]  RMS_GAIN        = 9'h102;
  localparam logic [RMS_W-1:0] RMS_SAT    = 24'hFFFFFF;

endpackage

// ==== hw/vrp_dly_if.sv ====
// carrier between the phase path and its delay-line memory
// assumes both ends share the master clock
interface vrp_dly_if;
  logic                       wr_en;
  logic [vrp_pkg::DLY_AW-1:0] wr_addr;
  logic [vrp_pkg::ADC_W-1:0]  wr_data;
  logic                       rd_en;
  logic [vrp_pkg::DLY_AW-1:0] rd_addr;
  logic [vrp_pkg::ADC_W-1:0]  rd_data;

  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input  rd_data);
  modport mem  (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output rd_data);
endinterface

// ==== hw/vrp_dly_mem.sv ====
// circular sample store for the tapped phase delay line
// assumes the controller owns both pointers; read data are registered
module vrp_dly_mem (
  // clock
  input  wire logic   core_clk_i,
  // delay-line port
  vrp_dly_if.mem      dly
);

  logic [vrp_pkg::ADC_W-1:0] store [2**vrp_pkg::DLY_AW];

  always_ff @(posedge core_clk_i) begin
    if (dly.wr_en) begin
      store[dly.wr_addr] <= dly.wr_data;
    end
  end

  // read before write on the same address returns the older sample
  always_ff @(posedge core_clk_i) begin
    if (dly.rd_en) begin
      dly.rd_data <= store[dly.rd_addr];
    end
  end

endmodule

// ==== test/vrp_host_model.sv ====
// host side of the voltage path: status read-and-clear, irq waiting
// assumes the bench drives all other controls at the falling edge
module vrp_host_model (
  // clock
  input  wire logic core_clk_i,
  // device side
  input  wire logic        irq_n_i,
  input  wire logic [23:0] waveform_i,
  input  wire logic [23:0] rms_i,
  output logic             status_read_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial status_read_o = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // one-cycle strobe, held across exactly one rising edge
  task automatic read_status();
    @(negedge core_clk_i);
    status_read_o = 1'b1;
    @(negedge core_clk_i);
    status_read_o = 1'b0;
  endtask

  // bounded wait for the request line to go low
  task automatic wait_irq(input int bound, output int n);
    n = 0;
    while (irq_n_i !== 1'b0 && n < bound) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  // rms taken just after the waveform changes sign, where the ripple at
  // twice the line rate is smallest; bounded when no crossing comes
  task automatic read_rms_zc(input int bound, output logic [23:0] v);
    logic s;
    int   k;
    s = waveform_i[23];
    k = 0;
    while (waveform_i[23] === s && k < bound) begin
      @(negedge core_clk_i);
      k++;
    end
    v = rms_i;
  endtask

  // offset from readings at a high and a low level, taking the rms error as a gain plus
  // one additive term; returns the correction to write
  function automatic logic [11:0] derive_offset(input longint hi_rd,
    input longint hi_ideal, input longint lo_rd, input longint lo_ideal);
    longint e;
    e = (lo_rd * hi_ideal - hi_rd * lo_ideal) / (hi_ideal - lo_ideal);
    return 12'(-e);
  endfunction
endmodule

// ==== test/vrp_voltage_path_bench.sv ====
// self-checking bench for the voltage rms and phase path
// assumes a 10 MHz clock; controls change at the falling edge only
module vrp_voltage_path_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] adc = 16'h0000;
  logic        vld = 1'b1;
  logic [2:0]  gain = 3'h0;
  logic [1:0]  wave = 2'h0;
  logic [1:0]  rate = 2'h0;
  logic        en = 1'b0;
  logic [11:0] ofs = 12'h000;
  logic [5:0]  trim = 6'h0D;
  logic        srd;
  logic [2:0]  pga;
  logic [23:0] wav;
  logic [23:0] rms;
  logic [23:0] pwr;
  logic        irq_n;
  int          cyc;
  int          mismatches = 0;
  int          num_checks = 0;
  int          lat[7];
  int          n;
  int          t1;
  logic [23:0] rv;

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  vrp_voltage_path u_dut (
    .core_clk_i            (clk),
    .rst_i                 (rst),
    .adc_sample_i          (adc),
    .adc_valid_i           (vld),
    .gain_sel_i            (gain),
    .pga_gain_o            (pga),
    .mode_wave_sel_i       (wave),
    .mode_rate_sel_i       (rate),
    .sample_ready_enable_i (en),
    .voltage_rms_offset_i  (ofs),
    .phase_delay_trim_i    (trim),
    .status_read_i         (srd),
    .waveform_o            (wav),
    .voltage_rms_value_o   (rms),
    .power_sample_o        (pwr),
    .irq_n_o               (irq_n)
  );

  vrp_host_model u_host (
    .core_clk_i    (clk),
    .irq_n_i       (irq_n),
    .waveform_i    (wav),
    .rms_i         (rms),
    .status_read_o (srd)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clk);
  endtask

  // latency of a step through the delay line, launched at a fixed phase
  task automatic step_lat(input logic [5:0] t, output int k);
    adc = 16'h0000;
    trim = t;
    cycles(600);
    while (cyc % 8 != 3) @(negedge clk);
    adc = 16'h1000;
    k = 0;
    while (pwr === 24'h000000 && k < 1000) begin
      @(negedge clk);
      k++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(2);
    chk(24'(pga), 24'h000000);
    chk(24'(irq_n), 24'h000001);
    chk(wav, 24'h000000);
    chk(rms, 24'h000000);
    chk(pwr, 24'h000000);
    @(negedge clk);
    rst = 1'b0;
    // zero input: the rms reads the offset alone, clamped at zero
    ofs = u_host.derive_offset(1561277, 1561400, 156017, 156140);
    cycles(6);
    chk(rms, 24'h00007B);
    ofs = 12'hF85;
    cycles(6);
    chk(rms, 24'h000000);
    ofs = 12'h7FF;
    n = 0;
    while (rms !== 24'h0007FF && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(24'(n <= 4), 24'h000001);
    ofs = 12'h000;
    for (int g = 0; g < 8; g++) begin
      gain = 3'(g);
      cycles(2);
      chk(24'(pga), (g > 4) ? 24'h000004 : 24'(g));
    end
    // tap spacing: one trim step is eight master clocks
    foreach (lat[i])
      step_lat(i == 0 ? 6'h0D : i == 1 ? 6'h0B : i == 2 ? 6'h0E :
               i == 3 ? 6'h1F : i == 4 ? 6'h1E : i == 5 ? 6'h21 : 6'h20,
               lat[i]);
    chk(24'(lat[0] - lat[1]), 24'h000010);
    chk(24'(lat[2] - lat[0]), 24'h000008);
    chk(24'(lat[3] - lat[4]), 24'h000008);
    chk(24'(lat[5]), 24'(lat[6]));
    chk(24'(lat[3] - lat[0]), 24'h000090);
    chk(24'(lat[5] < lat[0]), 24'h000001);
    trim = 6'h0D;
    // out-of-span input is clipped; the multiplier path is unfiltered
    adc = 16'h7FFF;
    cycles(600);
    chk(pwr, 24'h002852);
    adc = 16'h8000;
    cycles(600);
    chk(pwr, 24'hFFD7AE);
    // no load and no request outside the enabled voltage mode
    for (int m = 0; m < 5; m++) begin
      wave = (m == 3) ? 2'h3 : 2'(m % 3);
      en = (m < 3);
      cycles(300);
      chk(24'(irq_n), 24'h000001);
      chk(wav, 24'h000000);
    end
    en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wave = 2'h0;
      u_host.read_status();
      rate = 2'(c);
      wave = 2'h3;
      u_host.wait_irq(3000, n);
      t1 = cyc;
      u_host.read_status();
      chk(24'(irq_n), 24'h000001);
      u_host.wait_irq(3000, n);
      chk(24'(cyc - t1), 24'(128 << c));
    end
    rate = 2'h0;
    cycles(300);
    chk(24'(irq_n), 24'h000000);
    cycles(10000);
    chk(wav[23:16], {8{wav[15]}});
    chk(24'($signed(wav) < 0 && $signed(wav) > $signed(24'hFFD7AE)),
        24'h000001);
    u_host.read_rms_zc(200, rv);
    chk(24'(rv != 24'h000000), 24'h000001);
    stop_test();
  end

  // the whole sequence needs about 23k cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end
endmodule
